// ==== hw/eeprom_serial.sv ====
`timescale 1ns/1ps
module eeprom_serial import eeprom_pkg::*; #(
  // Arbitrary value
  parameter logic [TYPE_W-1:0] DEV_TYPE_CODE = 4'h5,
  parameter int WR_CYCLES = WR_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic LCLK,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [SEL_W-1:0] CHIP_SELECT_INPUTS,
  output logic BUSY
);
  localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(WR_CYCLES - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 17'h00001;
  typedef struct packed {
    logic tog_p;
    logic busy;
    logic [TIMER_W-1:0] cnt;
  } core_type;
  typedef struct packed {
    link_state_type state;
    logic scl_p;
    logic sda_p;
    logic [3:0] cnt;
    logic [BYTE_W-1:0] sh;
    logic [BYTE_W-1:0] tx_sh;
    logic rw;
    logic acked;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] fetch;
    logic wrote;
    logic pend;
    logic tog;
    logic oe;
    logic sda_lvl;
  } link_type;
  core_type c_q, c_d;
  link_type l_q, l_d;
  logic [BYTE_W-1:0] mem [MEM_WORDS];
  logic lrst_n, link_rst;
  logic scl_s, sda_s;
  logic [SEL_W-1:0] sel_s;
  logic busy_s, tog_s, busy_l;
  logic rise, fall, start, stop, rx_state;
  logic pop, flush, mem_we, load;
  logic in_ready, out_valid;
  logic [BYTE_W-1:0] out_data;
  function automatic logic addr_match(input logic [BYTE_W-1:0] b,
                                      input logic [SEL_W-1:0] sel);
    return (b[BYTE_W-1 -: TYPE_W] == DEV_TYPE_CODE) && (b[SEL_W:1] == sel);
  endfunction
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
    return a + ADDR_ONE;
  endfunction
  // Writes roll over inside the four-byte page
  function automatic logic [ADDR_W-1:0] page_next(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:PAGE_LOW_BITS],
            PAGE_LOW_BITS'(a[PAGE_LOW_BITS-1:0] + 1'b1)};
  endfunction
  // Link-side reset: asserted at once, released on LCLK
  bit_sync #(.W(1)) u_lrst (.clk(LCLK), .rst(RST), .d(1'b1), .q(lrst_n));
  assign link_rst = !lrst_n;
  bit_sync #(.W(2 + SEL_W)) u_pins (
    .clk(LCLK),
    .rst(link_rst),
    .d({SCL, SDA_IN, CHIP_SELECT_INPUTS}),
    .q({scl_s, sda_s, sel_s})
  );
  bit_sync #(.W(1)) u_busy (.clk(LCLK), .rst(link_rst), .d(c_q.busy), .q(busy_s));
  bit_sync #(.W(1)) u_tog (.clk(CLK), .rst(RST), .d(l_q.tog), .q(tog_s));
  // Read bytes are fetched ahead; the transmitter stalls the fetch when full
  pair_buf #(.W(BYTE_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(LCLK),
    .rst(link_rst),
    .flush(flush),
    .in_valid(1'b1),
    .in_ready(in_ready),
    .in_data(mem[l_q.fetch]),
    .out_valid(out_valid),
    .out_ready(pop),
    .out_data(out_data)
  );

  // Core domain: self-timed write cycle
  always_comb begin
    c_d = c_q;
    c_d.tog_p = tog_s;
    if (tog_s != c_q.tog_p) begin
      c_d.busy = 1'b1;
      c_d.cnt = TIMER_LOAD;
    end else if (c_q.busy) begin
      if (c_q.cnt == TIMER_ZERO) begin
        c_d.busy = 1'b0;
      end else begin
        c_d.cnt = c_q.cnt - TIMER_ONE;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign BUSY = c_q.busy;
  // Link domain: bus conditions from synchronised pins
  assign rise = !l_q.scl_p && scl_s;
  assign fall = l_q.scl_p && !scl_s;
  assign start = scl_s && l_q.scl_p && l_q.sda_p && !sda_s;
  assign stop = scl_s && l_q.scl_p && !l_q.sda_p && sda_s;
  assign rx_state = l_q.state inside {LS_DEV, LS_WADDR, LS_WDATA};
  // Pending covers the gap before the core's busy level arrives back
  assign busy_l = l_q.pend || busy_s;
  always_comb begin
    l_d = l_q;
    pop = 1'b0;
    flush = 1'b0;
    mem_we = 1'b0;
    load = 1'b0;
    l_d.scl_p = scl_s;
    l_d.sda_p = sda_s;
    l_d.sda_lvl = 1'b0;
    if (l_q.pend && busy_s) begin
      l_d.pend = 1'b0;
    end
    if (in_ready) begin
      l_d.fetch = next_addr(l_q.fetch);
    end
    if (start) begin
      l_d.state = LS_DEV;
      l_d.cnt = BIT_CNT_ZERO;
      l_d.oe = 1'b0;
      l_d.wrote = 1'b0;
    end else if (stop) begin
      if (l_q.wrote) begin
        l_d.tog = !l_q.tog;
        l_d.pend = 1'b1;
        l_d.wrote = 1'b0;
      end
      l_d.state = LS_IDLE;
      l_d.oe = 1'b0;
    end else begin
      if (rise && rx_state) begin
        l_d.sh = {l_q.sh[BYTE_W-2:0], sda_s};
        l_d.cnt = l_q.cnt + BIT_CNT_ONE;
      end
      unique case (l_q.state)
        LS_IDLE, LS_WAIT_STOP: begin
        end
        LS_DEV: begin
          if (fall && l_q.cnt == BITS_PER_BYTE) begin
            l_d.cnt = BIT_CNT_ZERO;
            if (addr_match(l_q.sh, sel_s) && !busy_l) begin
              l_d.oe = 1'b1;
              l_d.rw = l_q.sh[0];
              l_d.state = LS_DEV_ACK;
            end else begin
              l_d.state = LS_WAIT_STOP;
            end
          end
        end
        LS_DEV_ACK: begin
          if (fall) begin
            if (l_q.rw) begin
              load = 1'b1;
            end else begin
              l_d.oe = 1'b0;
              l_d.state = LS_WADDR;
            end
          end
        end
        LS_WADDR: begin
          if (fall && l_q.cnt == BITS_PER_BYTE) begin
            l_d.addr = l_q.sh;
            l_d.fetch = l_q.sh;
            flush = 1'b1;
            l_d.oe = 1'b1;
            l_d.cnt = BIT_CNT_ZERO;
            l_d.state = LS_WADDR_ACK;
          end
        end
        LS_WADDR_ACK, LS_WDATA_ACK: begin
          if (fall) begin
            l_d.oe = 1'b0;
            l_d.state = LS_WDATA;
          end
        end
        LS_WDATA: begin
          if (fall && l_q.cnt == BITS_PER_BYTE) begin
            mem_we = 1'b1;
            l_d.addr = page_next(l_q.addr);
            l_d.fetch = page_next(l_q.addr);
            flush = 1'b1;
            l_d.wrote = 1'b1;
            l_d.oe = 1'b1;
            l_d.cnt = BIT_CNT_ZERO;
            l_d.state = LS_WDATA_ACK;
          end
        end
        LS_TX: begin
          if (fall) begin
            if (l_q.cnt == BITS_PER_BYTE) begin
              l_d.oe = 1'b0;
              l_d.state = LS_TX_ACK;
            end else begin
              l_d.tx_sh = {l_q.tx_sh[BYTE_W-2:0], 1'b0};
              l_d.oe = !l_q.tx_sh[BYTE_W-2];
              l_d.cnt = l_q.cnt + BIT_CNT_ONE;
            end
          end
        end
        LS_TX_ACK: begin
          if (rise) begin
            l_d.acked = !sda_s;
          end
          if (fall) begin
            if (l_q.acked) begin
              load = 1'b1;
            end else begin
              l_d.oe = 1'b0;
              l_d.state = LS_WAIT_STOP;
            end
          end
        end
      endcase
      if (load) begin
        if (out_valid) begin
          // counter follows each byte sent, 8-bit wrap
          pop = 1'b1;
          l_d.tx_sh = out_data;
          l_d.oe = !out_data[BYTE_W-1];
          l_d.cnt = BIT_CNT_ONE;
          l_d.addr = next_addr(l_q.addr);
          l_d.state = LS_TX;
        end else begin
          l_d.oe = 1'b0;
          l_d.state = LS_WAIT_STOP;
        end
      end
    end
  end

  always_ff @(posedge LCLK or posedge link_rst) begin
    if (link_rst) begin
      l_q <= '{state: LS_IDLE, scl_p: 1'b1, sda_p: 1'b1, cnt: BIT_CNT_ZERO,
               addr: ADDR_RESET, fetch: ADDR_RESET, default: '0};
    end else begin
      l_q <= l_d;
    end
  end

  // Array kept out of reset so it maps onto memory
  always_ff @(posedge LCLK) begin
    if (mem_we) begin
      mem[l_q.addr] <= l_q.sh;
    end
  end

  assign SDA_OE = l_q.oe;
  assign SDA_OUT = l_q.sda_lvl;
  a_write_starts: assert property (@(posedge CLK) disable iff (RST)
    (tog_s != c_q.tog_p) |=> c_q.busy && c_q.cnt == TIMER_LOAD)
    else $error("write cycle did not start");
  a_busy_ends: assert property (@(posedge CLK) disable iff (RST)
    c_q.busy && c_q.cnt == TIMER_ZERO && tog_s == c_q.tog_p |=> !c_q.busy)
    else $error("write cycle did not end");
  a_busy_noack: assert property (@(posedge LCLK) disable iff (link_rst)
    l_q.state == LS_DEV && fall && l_q.cnt == BITS_PER_BYTE && busy_l && !start && !stop
    |=> !SDA_OE [*2])
    else $error("address acknowledged while busy");
  a_addr_ack: assert property (@(posedge LCLK) disable iff (link_rst)
    l_q.state == LS_DEV && fall && l_q.cnt == BITS_PER_BYTE && !busy_l && !start && !stop
    && addr_match(l_q.sh, sel_s) |=> SDA_OE && l_q.state == LS_DEV_ACK)
    else $error("matching address not acknowledged");
  a_tx_msb: assert property (@(posedge LCLK) disable iff (link_rst)
    pop |=> l_q.tx_sh == $past(out_data) && SDA_OE == !$past(out_data[BYTE_W-1])
    && l_q.state == LS_TX)
    else $error("byte not loaded msb first");
  a_word_load: assert property (@(posedge LCLK) disable iff (link_rst)
    l_q.state == LS_WADDR && fall && l_q.cnt == BITS_PER_BYTE && !start && !stop
    |=> l_q.addr == $past(l_q.sh) && !$past(mem_we))
    else $error("word address not loaded");
  a_seq_incr: assert property (@(posedge LCLK) disable iff (link_rst)
    pop |=> l_q.addr == next_addr($past(l_q.addr)))
    else $error("counter did not advance");
  a_nack_release: assert property (@(posedge LCLK) disable iff (link_rst)
    l_q.state == LS_TX_ACK && fall && !l_q.acked && !start && !stop
    |=> l_q.state == LS_WAIT_STOP && !SDA_OE)
    else $error("no release after missing acknowledge");
  a_start_fresh: assert property (@(posedge LCLK) disable iff (link_rst)
    start |=> l_q.state == LS_DEV && l_q.cnt == BIT_CNT_ZERO && !SDA_OE)
    else $error("start did not restart reception");

  c_read_ack: cover property (@(posedge LCLK) disable iff (link_rst)
    l_q.state == LS_DEV_ACK && l_q.rw && fall);
  c_seq_wrap: cover property (@(posedge LCLK) disable iff (link_rst)
    pop && l_q.addr == 8'hff);
  c_poll_reject: cover property (@(posedge LCLK) disable iff (link_rst)
    l_q.state == LS_DEV && fall && l_q.cnt == BITS_PER_BYTE && busy_l);
  c_nack_end: cover property (@(posedge LCLK) disable iff (link_rst)
    l_q.state == LS_TX_ACK && fall && !l_q.acked);
endmodule

// ==== include/eeprom_pkg.sv ====
package eeprom_pkg;
  localparam int ADDR_W = 8;
  localparam int BYTE_W = 8;
  localparam int MEM_WORDS = 256;
  localparam int SEL_W = 3;
  localparam int TYPE_W = 4;
  localparam int PAGE_LOW_BITS = 2;
  localparam int BUF_DEPTH = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_ONE = 4'h1;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  // Internal write cycle, typical figure
  localparam int WRITE_TIME_US = 5000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WR_CYCLES_DEF = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMER_W = 17;

  typedef enum logic [9:0] {
    LS_IDLE      = 10'h001,
    LS_DEV       = 10'h002,
    LS_DEV_ACK   = 10'h004,
    LS_WADDR     = 10'h008,
    LS_WADDR_ACK = 10'h010,
    LS_WDATA     = 10'h020,
    LS_WDATA_ACK = 10'h040,
    LS_TX        = 10'h080,
    LS_TX_ACK    = 10'h100,
    LS_WAIT_STOP = 10'h200
  } link_state_type;
endpackage

// ==== hw/bit_sync.sv ====
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_type;

  sync_type st_q, st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

// ==== hw/pair_buf.sv ====
`timescale 1ns/1ps
module pair_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] EMPTY = '0;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] data;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } buf_type;

  buf_type st_q, st_d;
  logic push, take;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == LAST) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready = (st_q.cnt != FULL);
  assign out_valid = (st_q.cnt != EMPTY);
  assign out_data = st_q.data[st_q.rp];
  assign push = in_valid && in_ready;
  assign take = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.data[st_q.wp] = in_data;
      st_d.wp = ptr_inc(st_q.wp);
    end
    if (take) begin
      st_d.rp = ptr_inc(st_q.rp);
    end
    st_d.cnt = CW'(st_q.cnt + CW'(push) - CW'(take));
    // Flush drops stale words after the address jumps
    if (flush) begin
      st_d.wp = '0;
      st_d.rp = '0;
      st_d.cnt = EMPTY;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ==== testbench/i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int HALF = 20
) (
  input wire logic clk,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic scl,
  output logic sda,
  output logic res_valid,
  output logic [8:0] res_data
);
  logic m_oe = 1'b0;
  // Pulled-up wire: the device shows its driven level, the master only pulls low
  assign sda = (dev_oe ? dev_out : 1'b1) && !m_oe;
  initial begin
    scl = 1'b1;
    res_valid = 1'b0;
    res_data = 9'h000;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic post(input logic [8:0] v);
    res_data = v;
    res_valid = 1'b1;
    #1 res_valid = 1'b0;
  endtask
  // Data moves only while the clock is low, never at its falling edge
  task automatic bit_out(input logic b);
    wt(2);
    m_oe = !b;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask
  task automatic start();
    wt(2);
    m_oe = 1'b0;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    m_oe = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(2);
    m_oe = 1'b1;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    m_oe = 1'b0;
    wt(HALF);
  endtask
  task automatic write_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    wt(2);
    m_oe = 1'b0;
    wt(HALF);
    scl = 1'b1;
    r = !sda;
    wt(HALF);
    scl = 1'b0;
    post({1'b1, 7'h00, r});
  endtask
  // acknowledge or withhold it on ninth clock
  task automatic read_byte(input logic ack);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      wt(2);
      m_oe = 1'b0;
      wt(HALF);
      scl = 1'b1;
      d[i] = sda;
      wt(HALF);
      scl = 1'b0;
    end
    bit_out(!ack);
    post({1'b0, d});
  endtask
endmodule

// ==== testbench/serial_eeprom_read_and_poll_tb_top.sv ====
`timescale 1ns/1ps
module serial_eeprom_read_and_poll_tb_top;
  import eeprom_pkg::*;
  localparam int WR_N = 2000;
  // Arbitrary value, matches the device type parameter below
  localparam logic [TYPE_W-1:0] TYPE_CODE = 4'h5;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic sda_out, sda_oe, busy, scl, sda, res_valid;
  logic [8:0] res_data;
  logic [SEL_W-1:0] sel = 3'h0;
  logic [7:0] mem_m [MEM_WORDS];
  logic [8:0] exp_q [$];
  logic [7:0] d;
  int failures = 0;
  int checks = 0;
  int seed_v;
  always #50 clk = ~clk;
  // Link clock offset so its edges never line up with the core clock
  initial begin
    #3.3;
    forever #6 lclk = ~lclk;
  end
  eeprom_serial #(.DEV_TYPE_CODE(TYPE_CODE), .WR_CYCLES(WR_N)) dut (
    .CLK(clk), .RST(rst), .LCLK(lclk), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .CHIP_SELECT_INPUTS(sel), .BUSY(busy));
  i2c_master_model #(.HALF(20)) mst (
    .clk(clk), .dev_oe(sda_oe), .dev_out(sda_out), .scl(scl), .sda(sda),
    .res_valid(res_valid), .res_data(res_data));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // 9'h1ff never comes from the model, so a result with no note fails
  always @(posedge res_valid) begin
    check(res_data, (exp_q.size() != 0) ? exp_q.pop_front() : 9'h1ff);
  end
  function automatic logic [7:0] dev(input logic rd);
    return {TYPE_CODE, sel, rd};
  endfunction
  task automatic wb(input logic [7:0] b, input logic ack);
    exp_q.push_back({1'b1, 7'h00, ack});
    mst.write_byte(b);
  endtask
  task automatic rb(input logic [7:0] a, input logic ack);
    exp_q.push_back({1'b0, mem_m[a]});
    mst.read_byte(ack);
  endtask
  task automatic page_write(input logic [7:0] a);
    mst.start();
    wb(dev(1'b0), 1'b1);
    wb(a, 1'b1);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      mem_m[8'(a + i)] = d;
      wb(d, 1'b1);
    end
    mst.stop();
    check({8'h00, busy}, 9'h001);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < WR_N + 50) begin
      @(posedge clk);
      n++;
    end
    check({8'h00, busy}, 9'h000);
    repeat (10) @(posedge clk);
    #5;
  endtask
  initial begin
    seed_v = $urandom(32'hf4c73bdc);
    repeat (4) @(posedge clk);
    #5;
    rst = 1'b0;
    sel = 3'($urandom);
    repeat (20) @(posedge clk);
    page_write(8'hfc);
    mst.start();
    wb(dev(1'b0), 1'b0);
    mst.stop();
    mst.start();
    wb(dev(1'b1), 1'b0);
    mst.stop();
    wait_idle();
    page_write(8'h00);
    wait_idle();
    // random read running across the wrap
    mst.start();
    wb(dev(1'b0), 1'b1);
    wb(8'hfd, 1'b1);
    mst.start();
    wb(dev(1'b1), 1'b1);
    for (int a = 'hfd; a < 'h103; a++) rb(8'(a), a != 'h102);
    mst.stop();
    // restart after address gives current read
    mst.start();
    wb(dev(1'b0), 1'b1);
    mst.start();
    wb(dev(1'b1), 1'b1);
    rb(8'h03, 1'b0);
    mst.stop();
    // line stays released after a withheld acknowledge
    mst.start();
    wb(dev(1'b0), 1'b1);
    wb(8'hfc, 1'b1);
    mst.start();
    wb(dev(1'b1), 1'b1);
    rb(8'hfc, 1'b0);
    exp_q.push_back(9'h0ff);
    mst.read_byte(1'b0);
    mst.stop();
    // select bits and type code must both match
    sel = 3'($urandom);
    repeat (10) @(posedge clk);
    #5;
    mst.start();
    wb({TYPE_CODE, sel ^ 3'h1, 1'b1}, 1'b0);
    mst.stop();
    mst.start();
    wb({TYPE_CODE ^ 4'h8, sel, 1'b1}, 1'b0);
    mst.stop();
    mst.start();
    wb(dev(1'b1), 1'b1);
    rb(8'hfd, 1'b0);
    mst.stop();
    repeat (10) @(posedge clk);
    check(9'(exp_q.size()), 9'h000);
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule
